// ### design/duart_irq_params.svh
`ifndef DUART_IRQ_PARAMS_SVH
`define DUART_IRQ_PARAMS_SVH

// Register indices on the word-addressed bus.
`define IDX_INPUT_CHANGE  5'h04
`define IDX_STATUS        5'h05
`define IDX_MODE_ZERO     5'h08
`define IDX_MODE_ONE      5'h09
`define IDX_AUX_CONTROL   5'h0A
`define IDX_CT_MODE       5'h0B
`define IDX_COMMAND       5'h10

// Command codes written to the command register.
`define CMD_RST_BRK_FIRST  8'h01
`define CMD_RST_BRK_SECOND 8'h02
`define CMD_STOP_COUNTER   8'h03

// Status and mask bit positions.
`define BIT_TX_FIRST    0
`define BIT_RX_FIRST    1
`define BIT_BRK_FIRST   2
`define BIT_CTR_READY   3
`define BIT_TX_SECOND   4
`define BIT_RX_SECOND   5
`define BIT_BRK_SECOND  6
`define BIT_INPUT_CHG   7

// Level fields inside the mode registers.
`define TX_LVL_MSB  5
`define TX_LVL_LSB  4
`define RX_LVL_BIT  6

`define STATUS_RESET 8'h00
`define MASK_RESET   8'h00
`define BYTE_RESET   8'h00

`endif

// ### design/duart_irq_pkg.sv
package duart_irq_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] level_sel_t;

endpackage

// ### design/irq_src_if.sv
`timescale 1ns/1ns

interface irq_src_if #(
    parameter int CW = 5
);
    logic [1:0][CW-1:0] rx_cnt;
    logic [1:0][CW-1:0] tx_cnt;
    logic [1:0]         rx_wdog;
    logic [1:0]         rx_lvl;
    logic [1:0]         tx_lvl;
    logic [1:0]         rx_service;
    logic [1:0]         tx_service;
    logic               ct_zero;
    logic               timer_mode;
    logic               stop_cmd;
    logic               counter_ready;

    modport core (
        output rx_cnt, tx_cnt, rx_wdog, rx_lvl, tx_lvl,
        output ct_zero, timer_mode, stop_cmd,
        input  rx_service, tx_service, counter_ready
    );
    modport level (
        input  rx_cnt, tx_cnt, rx_wdog, rx_lvl, tx_lvl,
        output rx_service, tx_service
    );
    modport ctr (
        input  ct_zero, timer_mode, stop_cmd,
        output counter_ready
    );
endinterface

// ### design/service_level.sv
`timescale 1ns/1ns

module service_level #(
    parameter int DEPTH = 16,
    parameter int CW    = 5
) (
    irq_src_if.level src
);
    localparam logic [CW-1:0] ONE  = CW'(1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
    localparam logic [CW-1:0] MOST = CW'((DEPTH * 3) / 4);

    // Fill test: 0 any, 1 half, 2 three quarters, 3 full.
    function automatic logic fill_ok(input logic [CW-1:0] c,
                                     input duart_irq_pkg::level_sel_t s);
        case (s)
            2'h0:    fill_ok = (c >= ONE);
            2'h1:    fill_ok = (c >= HALF);
            2'h2:    fill_ok = (c >= MOST);
            default: fill_ok = (c >= FULL);
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            src.rx_service[i] = fill_ok(src.rx_cnt[i], src.rx_lvl)
                                | src.rx_wdog[i];
            // Transmit level counts free slots; code 0 means empty.
            src.tx_service[i] = fill_ok(FULL - src.tx_cnt[i],
                                        ~src.tx_lvl);
        end
    end
endmodule

// ### design/counter_ready_track.sv
`timescale 1ns/1ns

module counter_ready_track (
    input wire logic clk,
    input wire logic rstn,
    irq_src_if.ctr   src
);
    logic phase;
    logic ready;
    logic next_phase;
    logic next_ready;

    always_comb begin
        next_phase = phase;
        next_ready = ready;
        if (src.stop_cmd) begin
            next_ready = 1'b0;
            if (!src.timer_mode) begin
                next_phase = 1'b0;
            end
        end
        if (src.ct_zero) begin
            if (src.timer_mode) begin
                next_phase = ~phase;
                if (phase) begin
                    next_ready = 1'b1;
                end
            end else begin
                next_ready = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase <= 1'b0;
            ready <= 1'b0;
        end else begin
            phase <= next_phase;
            ready <= next_ready;
        end
    end

    assign src.counter_ready = ready;

    property p_ctr_set;
        @(posedge clk) disable iff (!rstn)
        (!src.timer_mode && src.ct_zero) |=> ready;
    endproperty
    a_ctr_set: assert property (p_ctr_set)
        else $error("counter mode zero did not set ready");

    property p_stop_clr;
        @(posedge clk) disable iff (!rstn)
        (src.stop_cmd && !src.ct_zero) |=> !ready;
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("stop command did not clear ready");

    sequence s_timer_zero;
        src.timer_mode && src.ct_zero && !src.stop_cmd;
    endsequence

    property p_timer_two;
        @(posedge clk) disable iff (!rstn)
        s_timer_zero ##0 phase |=> ready;
    endproperty
    a_timer_two: assert property (p_timer_two)
        else $error("timer two zeros did not set ready");

    property p_timer_one;
        @(posedge clk) disable iff (!rstn)
        s_timer_zero ##0 (!phase && !ready) |=> !ready;
    endproperty
    a_timer_one: assert property (p_timer_one)
        else $error("timer first zero set ready");
endmodule

// ### design/duart_irq_core.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "duart_irq_params.svh"

module duart_irq_core #(
    parameter int DEPTH = 16,
    parameter int CW    = 5
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [4:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          break_change_first,
    input  wire logic          break_change_second,
    input  wire logic [CW-1:0] rx_fifo_count_first,
    input  wire logic [CW-1:0] rx_fifo_count_second,
    input  wire logic          rx_watchdog_first,
    input  wire logic          rx_watchdog_second,
    input  wire logic [CW-1:0] tx_fifo_count_first,
    input  wire logic [CW-1:0] tx_fifo_count_second,
    input  wire logic          ct_zero,
    input  wire logic [3:0]    input_change,
    input  wire logic [3:0]    input_state,
    output logic               irq_out_n
);
    // ************************************************************
    // Declarations
    // ************************************************************
    duart_irq_pkg::bus_state_e state;
    duart_irq_pkg::bus_state_e next_state;
    logic                      next_waitrequest;
    logic [31:0]               next_readdata;

    duart_irq_pkg::byte_t      status;
    duart_irq_pkg::byte_t      mask;
    duart_irq_pkg::byte_t      mode_reg_zero;
    duart_irq_pkg::byte_t      mode_reg_one;
    logic [3:0]                aux_control_reg;
    logic                      timer_mode;
    logic [3:0]                change_latch;
    duart_irq_pkg::byte_t      next_status;
    duart_irq_pkg::byte_t      next_mask;
    duart_irq_pkg::byte_t      next_mode_zero;
    duart_irq_pkg::byte_t      next_mode_one;
    logic [3:0]                next_aux;
    logic                      next_timer_mode;
    logic [3:0]                next_change_latch;
    logic                      next_irq_out_n;

    logic                      done;
    logic                      wr_done;
    logic                      rd_done;
    logic                      rst_brk_first;
    logic                      rst_brk_second;
    logic                      change_read;
    duart_irq_pkg::byte_t      read_mux;

    irq_src_if #(.CW(CW)) src ();

    // ************************************************************
    // Source conditioning
    // ************************************************************
    assign src.rx_cnt     = {rx_fifo_count_second, rx_fifo_count_first};
    assign src.tx_cnt     = {tx_fifo_count_second, tx_fifo_count_first};
    assign src.rx_wdog    = {rx_watchdog_second, rx_watchdog_first};
    assign src.rx_lvl     = {mode_reg_zero[`RX_LVL_BIT],
                             mode_reg_one[`RX_LVL_BIT]};
    assign src.tx_lvl     = mode_reg_zero[`TX_LVL_MSB:`TX_LVL_LSB];
    assign src.ct_zero    = ct_zero;
    assign src.timer_mode = timer_mode;

    service_level #(
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_level (
        .src (src.level)
    );

    counter_ready_track u_ctr (
        .clk  (clk),
        .rstn (rstn),
        .src  (src.ctr)
    );

    // ************************************************************
    // Bus slave
    // ************************************************************
    assign done    = (state == duart_irq_pkg::BUS_ACK);
    assign wr_done = done && avs_write;
    assign rd_done = done && avs_read;

    always_comb begin
        case (avs_address)
            `IDX_STATUS:       read_mux = status;
            `IDX_INPUT_CHANGE: read_mux = {change_latch, input_state};
            `IDX_MODE_ZERO:    read_mux = mode_reg_zero;
            `IDX_MODE_ONE:     read_mux = mode_reg_one;
            `IDX_AUX_CONTROL:  read_mux = {4'h0, aux_control_reg};
            `IDX_CT_MODE:      read_mux = {7'h00, timer_mode};
            default:           read_mux = `BYTE_RESET;
        endcase
    end

    always_comb begin
        next_state       = state;
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        case (state)
            duart_irq_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state       = duart_irq_pkg::BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = {24'h000000, read_mux};
                end
            end
            duart_irq_pkg::BUS_ACK: begin
                next_state = duart_irq_pkg::BUS_IDLE;
            end
            default: begin
                next_state = duart_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state           <= duart_irq_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            state           <= next_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // ************************************************************
    // Commands and side effects
    // ************************************************************
    assign rst_brk_first  = wr_done && (avs_address == `IDX_COMMAND)
                            && (avs_writedata[7:0] == `CMD_RST_BRK_FIRST);
    assign rst_brk_second = wr_done && (avs_address == `IDX_COMMAND)
                            && (avs_writedata[7:0] == `CMD_RST_BRK_SECOND);
    assign src.stop_cmd   = wr_done && (avs_address == `IDX_COMMAND)
                            && (avs_writedata[7:0] == `CMD_STOP_COUNTER);
    assign change_read    = rd_done && (avs_address == `IDX_INPUT_CHANGE);

    // ************************************************************
    // Registers, status and request
    // ************************************************************
    always_comb begin
        next_mask         = mask;
        next_mode_zero    = mode_reg_zero;
        next_mode_one     = mode_reg_one;
        next_aux          = aux_control_reg;
        next_timer_mode   = timer_mode;
        next_status       = status;
        next_change_latch = change_latch;
        if (wr_done) begin
            case (avs_address)
                `IDX_STATUS:      next_mask = avs_writedata[7:0];
                `IDX_MODE_ZERO:   next_mode_zero = avs_writedata[7:0];
                `IDX_MODE_ONE:    next_mode_one = avs_writedata[7:0];
                `IDX_AUX_CONTROL: next_aux = avs_writedata[3:0];
                `IDX_CT_MODE:     next_timer_mode = avs_writedata[0];
                default:          next_mask = mask;
            endcase
        end
        if (rst_brk_first) begin
            next_status[`BIT_BRK_FIRST] = 1'b0;
        end
        if (break_change_first) begin
            next_status[`BIT_BRK_FIRST] = 1'b1;
        end
        if (rst_brk_second) begin
            next_status[`BIT_BRK_SECOND] = 1'b0;
        end
        if (break_change_second) begin
            next_status[`BIT_BRK_SECOND] = 1'b1;
        end
        if (change_read) begin
            next_change_latch            = 4'h0;
            next_status[`BIT_INPUT_CHG] = 1'b0;
        end
        next_change_latch = next_change_latch | input_change;
        if (|(input_change & aux_control_reg)) begin
            next_status[`BIT_INPUT_CHG] = 1'b1;
        end
        next_status[`BIT_RX_FIRST]  = src.rx_service[0];
        next_status[`BIT_RX_SECOND] = src.rx_service[1];
        next_status[`BIT_TX_FIRST]  = src.tx_service[0];
        next_status[`BIT_TX_SECOND] = src.tx_service[1];
        next_status[`BIT_CTR_READY] = src.counter_ready;
        next_irq_out_n = ~|(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            status          <= `STATUS_RESET;
            mask            <= `MASK_RESET;
            mode_reg_zero   <= `BYTE_RESET;
            mode_reg_one    <= `BYTE_RESET;
            aux_control_reg <= 4'h0;
            timer_mode      <= 1'b0;
            change_latch    <= 4'h0;
            irq_out_n       <= 1'b1;
        end else begin
            status          <= next_status;
            mask            <= next_mask;
            mode_reg_zero   <= next_mode_zero;
            mode_reg_one    <= next_mode_one;
            aux_control_reg <= next_aux;
            timer_mode      <= next_timer_mode;
            change_latch    <= next_change_latch;
            irq_out_n       <= next_irq_out_n;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_irq_low;
        (|(status & mask)) |-> !irq_out_n;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("request high with unmasked status");

    property p_irq_high;
        ((status & mask) == 8'h00) |-> irq_out_n;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("request low with all status masked");

    property p_brk_first;
        break_change_first |=> status[`BIT_BRK_FIRST];
    endproperty
    a_brk_first: assert property (p_brk_first)
        else $error("first break change lost");

    property p_brk_second_hold;
        (status[`BIT_BRK_SECOND] && !rst_brk_second)
        |=> status[`BIT_BRK_SECOND];
    endproperty
    a_brk_second_hold: assert property (p_brk_second_hold)
        else $error("second break bit dropped without command");

    property p_rx_first;
        src.rx_service[0] |=> status[`BIT_RX_FIRST];
    endproperty
    a_rx_first: assert property (p_rx_first)
        else $error("first receiver service not shown");

    property p_tx_second;
        !src.tx_service[1] |=> !status[`BIT_TX_SECOND];
    endproperty
    a_tx_second: assert property (p_tx_second)
        else $error("second transmit bit without service");

    sequence s_status_read;
        done && avs_read && (avs_address == `IDX_STATUS);
    endsequence

    property p_status_read;
        s_status_read |-> (avs_readdata[7:0] == $past(status))
            ##1 ($past(status[`BIT_BRK_FIRST]) -> status[`BIT_BRK_FIRST]);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong or clearing");

    property p_change_clr;
        (change_read && !(|(input_change & aux_control_reg)))
        |=> !status[`BIT_INPUT_CHG];
    endproperty
    a_change_clr: assert property (p_change_clr)
        else $error("input change bit not cleared by read");

    property p_bus_ack;
        ((avs_read || avs_write) && !done)
        |=> (!avs_waitrequest ##1 avs_waitrequest);
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus answer not one cycle");
endmodule

// ### tb/duart_host_model.sv
`timescale 1ns/1ns
`include "duart_irq_params.svh"

// ****************************************************************
// Host processor that reaches the status and mask over the bus.
// ****************************************************************
module duart_host_model (
    input  wire logic        clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    initial begin
        avs_address   = 5'h00;
        avs_read      = 1'h0;
        avs_write     = 1'h0;
        avs_writedata = 32'h00000000;
    end

    // The request stands until waitrequest is sampled low.
    task automatic access(input logic wr, input logic [4:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {24'h000000, d};
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) @(posedge clk);
        q = avs_readdata[7:0];
        avs_read      <= 1'h0;
        avs_write     <= 1'h0;
        avs_writedata <= ~avs_writedata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        access(1'h0, a, 8'h00, q);
    endtask

    task automatic command(input logic [7:0] c);
        wr(`IDX_COMMAND, c);
    endtask
endmodule

// ### tb/duart_interrupt_status_mask_test.sv
`timescale 1ns/1ns
`include "duart_irq_params.svh"
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected %s expected %h seen %h", what, exp, got); \
        end \
    end

// ****************************************************************
// Scenarios on the status, mask and interrupt request.
// ****************************************************************
module duart_interrupt_status_mask_test;
    logic        clk;
    logic        rstn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  brk;
    logic [1:0]  watchdog;
    logic [4:0]  rx_count [2];
    logic [4:0]  tx_count [2];
    logic        ct_zero;
    logic [3:0]  input_change;
    logic [3:0]  input_state;
    logic        irq_out_n;
    int          err_count = 0;
    int          compares  = 0;
    int          cycles    = 0;

    duart_host_model host_u (
        .clk(clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata)
    );

    duart_irq_core #(.DEPTH(16), .CW(5)) dut_u (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .break_change_first(brk[0]), .break_change_second(brk[1]),
        .rx_fifo_count_first(rx_count[0]),
        .rx_fifo_count_second(rx_count[1]),
        .rx_watchdog_first(watchdog[0]), .rx_watchdog_second(watchdog[1]),
        .tx_fifo_count_first(tx_count[0]),
        .tx_fifo_count_second(tx_count[1]),
        .ct_zero(ct_zero), .input_change(input_change),
        .input_state(input_state), .irq_out_n(irq_out_n)
    );

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic expect_status(input logic [7:0] exp, input logic irq_n);
        logic [7:0] q;
        host_u.rd(`IDX_STATUS, q);
        @(negedge clk);
        `CHK("interrupt_status", exp, q)
        `CHK("irq_out_n", irq_n, irq_out_n)
    endtask

    task automatic pulse_zero();
        @(posedge clk);
        ct_zero <= 1'h1;
        @(posedge clk);
        ct_zero <= 1'h0;
    endtask

    task automatic test_reset();
        logic [7:0] q;
        repeat (7) @(posedge clk);
        @(negedge clk);
        `CHK("irq_out_n", 1'h1, irq_out_n)
        @(posedge clk);
        rstn <= 1'h1;
        expect_status(8'h00, 1'h1);
        host_u.rd(5'h1F, q);
        `CHK("unmapped", 8'h00, q)
        done("reset");
    endtask

    task automatic test_break();
        logic [7:0] m;
        for (int ch = 0; ch < 2; ch++) begin
            m = ch ? 8'h40 : 8'h04;
            @(posedge clk);
            brk[ch] <= 1'h1;
            @(posedge clk);
            brk[ch] <= 1'h0;
            expect_status(m, 1'h1);
            expect_status(m, 1'h1);
            host_u.wr(`IDX_STATUS, m);
            expect_status(m, 1'h0);
            host_u.wr(`IDX_STATUS, ~m);
            expect_status(m, 1'h1);
            host_u.command(ch ? `CMD_RST_BRK_SECOND : `CMD_RST_BRK_FIRST);
            expect_status(8'h00, 1'h1);
            host_u.wr(`IDX_STATUS, 8'h00);
        end
        done("break");
    endtask

    task automatic test_rx();
        int         at [4] = '{1, 8, 12, 16};
        logic [7:0] m;
        for (int c = 0; c < 4; c++) begin
            host_u.wr(`IDX_MODE_ZERO, c[1] ? 8'h40 : 8'h00);
            host_u.wr(`IDX_MODE_ONE, c[0] ? 8'h40 : 8'h00);
            for (int ch = 0; ch < 2; ch++) begin
                m = ch ? 8'h20 : 8'h02;
                @(posedge clk);
                rx_count[ch] <= 5'(at[c] - 1);
                expect_status(8'h00, 1'h1);
                @(posedge clk);
                rx_count[ch] <= 5'(at[c]);
                expect_status(m, 1'h1);
                @(posedge clk);
                rx_count[ch] <= 5'h00;
                watchdog[ch] <= 1'h1;
                expect_status(m, 1'h1);
                @(posedge clk);
                watchdog[ch] <= 1'h0;
            end
        end
        done("rx");
    endtask

    task automatic test_tx();
        int         ok [4] = '{0, 4, 8, 15};
        logic [7:0] m;
        for (int c = 0; c < 4; c++) begin
            host_u.wr(`IDX_MODE_ZERO, 8'(c << 4));
            for (int ch = 0; ch < 2; ch++) begin
                m = ch ? 8'h10 : 8'h01;
                @(posedge clk);
                tx_count[ch] <= 5'(ok[c]);
                expect_status(m, 1'h1);
                @(posedge clk);
                tx_count[ch] <= 5'(ok[c] + 1);
                expect_status(8'h00, 1'h1);
                @(posedge clk);
                tx_count[ch] <= 5'h10;
            end
        end
        done("tx");
    endtask

    task automatic test_counter();
        host_u.wr(`IDX_STATUS, 8'h08);
        host_u.wr(`IDX_CT_MODE, 8'h00);
        pulse_zero();
        expect_status(8'h08, 1'h0);
        host_u.command(`CMD_STOP_COUNTER);
        expect_status(8'h00, 1'h1);
        host_u.wr(`IDX_CT_MODE, 8'h01);
        for (int k = 0; k < 4; k++) begin
            pulse_zero();
            expect_status(k[0] ? 8'h08 : 8'h00, !k[0]);
            if (k[0]) begin
                host_u.command(`CMD_STOP_COUNTER);
                expect_status(8'h00, 1'h1);
            end
        end
        host_u.wr(`IDX_STATUS, 8'h00);
        done("counter");
    endtask

    task automatic test_input();
        logic [7:0] q;
        host_u.wr(`IDX_AUX_CONTROL, 8'h01);
        host_u.wr(`IDX_STATUS, 8'h80);
        @(posedge clk);
        input_state  <= 4'hA;
        input_change <= 4'h1;
        @(posedge clk);
        input_change <= 4'h0;
        expect_status(8'h80, 1'h0);
        host_u.rd(`IDX_INPUT_CHANGE, q);
        `CHK("input_change_reg", 8'h1A, q)
        expect_status(8'h00, 1'h1);
        @(posedge clk);
        input_change <= 4'h2;
        @(posedge clk);
        input_change <= 4'h0;
        expect_status(8'h00, 1'h1);
        host_u.rd(`IDX_INPUT_CHANGE, q);
        `CHK("input_change_reg", 8'h2A, q)
        done("input");
    endtask

    initial begin
        rstn         = 1'h0;
        brk          = 2'h0;
        watchdog     = 2'h0;
        rx_count     = '{5'h00, 5'h00};
        tx_count     = '{5'h10, 5'h10};
        ct_zero      = 1'h0;
        input_change = 4'h0;
        input_state  = 4'h0;
        test_reset();
        test_break();
        test_rx();
        test_tx();
        test_counter();
        test_input();
        end_sim();
    end
endmodule
